// ### sub_alu.sv
`timescale 1ns/1ps
`default_nettype none

module sub_alu (
  input  wire logic                  [31:0] minuend,
  input  wire logic                  [31:0] subtrahend,
  input  wire sub_exec_pkg::op_size_t       op_size,
  output logic                       [31:0] difference,
  output logic                              neg,
  output logic                              zero,
  output logic                              ovf,
  output logic                              borrow
);
  logic [8:0]  diff_b;
  logic [16:0] diff_w;
  logic [32:0] diff_l;
  logic        a_msb;
  logic        b_msb;

  // ---------------------------------------------------------------
  // sized subtraction; bits above the size keep the minuend
  // ---------------------------------------------------------------
  always_comb begin
    diff_b = {1'b0, minuend[7:0]} - {1'b0, subtrahend[7:0]};
    diff_w = {1'b0, minuend[15:0]} - {1'b0, subtrahend[15:0]};
    diff_l = {1'b0, minuend} - {1'b0, subtrahend};
    unique case (op_size)
      sub_exec_pkg::size_byte: begin
        difference = {minuend[31:8], diff_b[7:0]};
        borrow     = diff_b[8];                                  // RL5
        zero       = (diff_b[7:0] == 8'h00);                     // RL3
        neg        = diff_b[7];                                  // RL2
        a_msb      = minuend[7];
        b_msb      = subtrahend[7];
      end
      sub_exec_pkg::size_word: begin
        difference = {minuend[31:16], diff_w[15:0]};
        borrow     = diff_w[16];                                 // RL5
        zero       = (diff_w[15:0] == 16'h0000);                 // RL3
        neg        = diff_w[15];                                 // RL2
        a_msb      = minuend[15];
        b_msb      = subtrahend[15];
      end
      default: begin
        difference = diff_l[31:0];
        borrow     = diff_l[32];                                 // RL5
        zero       = (diff_l[31:0] == 32'h0000_0000);            // RL3
        neg        = diff_l[31];                                 // RL2
        a_msb      = minuend[31];
        b_msb      = subtrahend[31];
      end
    endcase
    // signs differ and result sign left the minuend's sign
    ovf = (a_msb != b_msb) && (neg != a_msb);                    // RL4
  end
endmodule // sub_alu

`default_nettype wire

// ### sub_ea_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "sub_exec_params.svh"

module sub_ea_check (
  input  wire logic [2:0] ea_mode,
  input  wire logic [2:0] ea_reg,
  input  wire logic       ea_is_dest,
  input  wire logic       byte_size,
  output logic            ea_legal
);
  // ---------------------------------------------------------------
  // addressing mode legality
  // ---------------------------------------------------------------
  always_comb begin
    if (ea_is_dest) begin
      // memory alterable only: no register direct, pc-relative or data
      ea_legal = ((ea_mode >= `EA_MODE_INDIRECT) &&
                  (ea_mode <= `EA_MODE_INDEXED)) ||
                 ((ea_mode == `EA_MODE_EXTENDED) &&
                  (ea_reg <= `EA_REG_ABS_LONG));                 // RL11
    end else begin
      // every source mode, immediate included, except address direct at byte size
      ea_legal = !((ea_mode == `EA_MODE_ADDR_DIRECT) && byte_size) && // RL10
                 !((ea_mode == `EA_MODE_EXTENDED) &&
                   (ea_reg > `EA_REG_IMMEDIATE));                // RL9 RL17
    end
  end
endmodule // sub_ea_check

`default_nettype wire

// ### sub_exec_params.svh
`ifndef SUB_EXEC_PARAMS_SVH
`define SUB_EXEC_PARAMS_SVH

// ---------------------------------------------------------------
// opcode group and operation-mode codes
// ---------------------------------------------------------------
`define SUB_OPCODE_GROUP   4'hD
`define OPM_EA_MINUS_REG_B 3'h0
`define OPM_EA_MINUS_REG_W 3'h1
`define OPM_EA_MINUS_REG_L 3'h2
`define OPM_TO_ADDR_W      3'h3
`define OPM_REG_MINUS_EA_B 3'h4
`define OPM_REG_MINUS_EA_W 3'h5
`define OPM_REG_MINUS_EA_L 3'h6
`define OPM_TO_ADDR_L      3'h7

// ---------------------------------------------------------------
// instruction word field positions
// ---------------------------------------------------------------
`define FLD_GROUP_HI 15
`define FLD_GROUP_LO 12
`define FLD_REG_HI   11
`define FLD_REG_LO   9
`define FLD_OPM_HI   8
`define FLD_OPM_LO   6
`define FLD_MODE_HI  5
`define FLD_MODE_LO  3
`define FLD_EAREG_HI 2
`define FLD_EAREG_LO 0

// ---------------------------------------------------------------
// effective address mode and register codes
// ---------------------------------------------------------------
`define EA_MODE_DATA_DIRECT 3'h0
`define EA_MODE_ADDR_DIRECT 3'h1
`define EA_MODE_INDIRECT    3'h2
`define EA_MODE_INDEXED     3'h6
`define EA_MODE_EXTENDED    3'h7
`define EA_REG_ABS_LONG     3'h1
`define EA_REG_IMMEDIATE    3'h4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RESULT_RESET 32'h0000_0000
`define INDEX_RESET  3'h0

`endif

// ### sub_exec_pkg.sv
package sub_exec_pkg;
  typedef enum logic [1:0] {
    size_byte,
    size_word,
    size_long
  } op_size_t;

  typedef enum logic [1:0] {
    form_none,
    form_to_data_reg,
    form_to_ea,
    form_to_addr_reg
  } exec_form_t;
endpackage

// ### sub_operand_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------
// register file and memory path stand-in
// ------------------------------------------
module sub_operand_model (
  input  wire logic [15:0] instr_word,
  input  wire logic [31:0] mem_value,
  output logic      [31:0] reg_operand,
  output logic      [31:0] ea_operand
);
  logic [31:0] data_reg [8];
  logic [31:0] addr_reg [8];
  logic [2:0]  sel;
  logic        to_addr;

  // mixed signs so every flag gets a chance to move
  initial begin
    for (int i = 0; i < 8; i++) begin
      data_reg[i] = 32'h8000_0001 + i * 32'h0101_0101;
      addr_reg[i] = 32'h0000_7FF0 + i * 32'h0010_0000;
    end
  end

  assign sel         = instr_word[11:9];
  assign to_addr     = instr_word[7:6] == 2'h3;
  assign reg_operand = to_addr ? addr_reg[sel] : data_reg[sel];
  // operand already fetched, whatever its addressing mode
  assign ea_operand  = mem_value;
endmodule // sub_operand_model

`default_nettype wire

// ### subtract_and_subtract_address_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "sub_exec_params.svh"

// Overview of operation
// RL1: extend flag takes the same value as the borrow flag.
// RL2: negative flag is the top bit of the sized result.
// RL3: zero flag set when every sized result bit is zero.
// RL4: overflow flag set on signed overflow at the chosen size.
// RL5: carry flag set when the unsigned subtraction borrows.
// RL6: register field picks one of eight data registers.
// RL7: modes 000/001/010 compute operand minus data register into register.
// RL8: modes 100/101/110 compute data register minus operand into operand.
// RL9: as source, every addressing mode is legal, immediate included.
// RL10: byte size with address register direct source is illegal.
// RL11: as destination, only memory alterable modes are legal.
// RL12: software names a data register destination via the register field.
// RL13: address form stores into the address register, flags untouched.
// RL14: address form sign-extends a word source to 32 bits.
// RL15: mode 011 is word source, 111 long; all 32 bits updated.
// RL16: address form register field picks one of eight address registers.
// RL17: address form accepts every source mode, address direct included.
// RL18: modes 011 and 111 route to the address form path.
module subtract_and_subtract_address_exec (
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  input  wire logic                         instr_valid,
  input  wire logic                  [15:0] instr_word,
  input  wire logic                  [31:0] reg_operand,
  input  wire logic                  [31:0] ea_operand,
  output logic                              exec_done,
  output logic                              illegal_instr,
  output logic                       [31:0] result_data,
  output sub_exec_pkg::exec_form_t          result_form,
  output logic                       [2:0]  result_reg_index,
  output sub_exec_pkg::op_size_t            result_size,
  output logic                              flags_write,
  output logic                              flag_x,
  output logic                              flag_n,
  output logic                              flag_z,
  output logic                              flag_v,
  output logic                              flag_c
);
  // ---------------------------------------------------------------
  // instruction fields
  // ---------------------------------------------------------------
  logic [3:0] group_code;
  logic [2:0] reg_field;
  logic [2:0] opmode;
  logic [2:0] ea_mode;
  logic [2:0] ea_reg;

  assign group_code = instr_word[`FLD_GROUP_HI:`FLD_GROUP_LO];
  assign reg_field  = instr_word[`FLD_REG_HI:`FLD_REG_LO];
  assign opmode     = instr_word[`FLD_OPM_HI:`FLD_OPM_LO];
  assign ea_mode    = instr_word[`FLD_MODE_HI:`FLD_MODE_LO];
  assign ea_reg     = instr_word[`FLD_EAREG_HI:`FLD_EAREG_LO];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic                     claimed;
  sub_exec_pkg::exec_form_t form;
  sub_exec_pkg::op_size_t   size;
  logic                     ea_is_dest;
  logic                     ea_legal;
  logic [31:0]              op_a;
  logic [31:0]              op_b;

  always_comb begin
    claimed = instr_valid && (group_code == `SUB_OPCODE_GROUP);
    unique case (opmode)
      `OPM_EA_MINUS_REG_B, `OPM_EA_MINUS_REG_W, `OPM_EA_MINUS_REG_L:
        form = sub_exec_pkg::form_to_data_reg;                   // RL7
      `OPM_REG_MINUS_EA_B, `OPM_REG_MINUS_EA_W, `OPM_REG_MINUS_EA_L:
        form = sub_exec_pkg::form_to_ea;                         // RL8
      default:
        form = sub_exec_pkg::form_to_addr_reg;                   // RL18
    endcase
    unique case (opmode)
      `OPM_EA_MINUS_REG_B, `OPM_REG_MINUS_EA_B:
        size = sub_exec_pkg::size_byte;
      `OPM_EA_MINUS_REG_W, `OPM_REG_MINUS_EA_W, `OPM_TO_ADDR_W:
        size = sub_exec_pkg::size_word;                          // RL15
      default:
        size = sub_exec_pkg::size_long;                          // RL15
    endcase
    ea_is_dest = (form == sub_exec_pkg::form_to_ea);
    // minuend follows the opmode table, not the destination
    unique case (form)
      sub_exec_pkg::form_to_ea: begin
        op_a = reg_operand;                                      // RL8
        op_b = ea_operand;
      end
      sub_exec_pkg::form_to_addr_reg: begin
        op_a = reg_operand;                                      // RL13
        if (opmode == `OPM_TO_ADDR_W)
          op_b = {{16{ea_operand[15]}}, ea_operand[15:0]};       // RL14
        else
          op_b = ea_operand;
      end
      default: begin
        // reg_operand is the data register named by reg_field
        op_a = ea_operand;                                       // RL7 RL6
        op_b = reg_operand;
      end
    endcase
  end

  sub_ea_check u_ea_check (
    .ea_mode    (ea_mode),
    .ea_reg     (ea_reg),
    .ea_is_dest (ea_is_dest),
    .byte_size  (size == sub_exec_pkg::size_byte),
    .ea_legal   (ea_legal)
  );

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  logic [31:0]            alu_diff;
  logic                   alu_n;
  logic                   alu_z;
  logic                   alu_v;
  logic                   alu_c;
  sub_exec_pkg::op_size_t alu_size;

  // address form always works on the whole register
  assign alu_size = (form == sub_exec_pkg::form_to_addr_reg) ?
                    sub_exec_pkg::size_long : size;              // RL15

  sub_alu u_alu (
    .minuend    (op_a),
    .subtrahend (op_b),
    .op_size    (alu_size),
    .difference (alu_diff),
    .neg        (alu_n),
    .zero       (alu_z),
    .ovf        (alu_v),
    .borrow     (alu_c)
  );

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  logic                     next_exec_done;
  logic                     next_illegal_instr;
  logic [31:0]              next_result_data;
  sub_exec_pkg::exec_form_t next_result_form;
  logic [2:0]               next_result_reg_index;
  sub_exec_pkg::op_size_t   next_result_size;
  logic                     next_flags_write;
  logic [4:0]               next_flags;

  always_comb begin
    next_exec_done        = claimed;
    next_illegal_instr    = 1'b0;
    next_result_data      = result_data;
    next_result_form      = sub_exec_pkg::form_none;
    next_result_reg_index = result_reg_index;
    next_result_size      = result_size;
    next_flags_write      = 1'b0;
    // flags hold unless a general subtract retires
    next_flags = {flag_x, flag_n, flag_z, flag_v, flag_c};
    if (claimed) begin
      if (!ea_legal) begin
        // nothing is written for an illegal form
        next_illegal_instr = 1'b1;                               // RL10 RL11
      end else begin
        next_result_data      = alu_diff;
        next_result_form      = form;
        next_result_reg_index = reg_field;                       // RL6 RL16
        next_result_size      = alu_size;
        if (form != sub_exec_pkg::form_to_addr_reg) begin
          next_flags_write = 1'b1;
          next_flags = {alu_c, alu_n, alu_z, alu_v, alu_c};      // RL1
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      exec_done        <= 1'b0;
      illegal_instr    <= 1'b0;
      result_data      <= `RESULT_RESET;
      result_form      <= sub_exec_pkg::form_none;
      result_reg_index <= `INDEX_RESET;
      result_size      <= sub_exec_pkg::size_byte;
      flags_write      <= 1'b0;
      {flag_x, flag_n, flag_z, flag_v, flag_c} <= 5'h00;
    end else begin
      exec_done        <= next_exec_done;
      illegal_instr    <= next_illegal_instr;
      result_data      <= next_result_data;
      result_form      <= next_result_form;
      result_reg_index <= next_result_reg_index;
      result_size      <= next_result_size;
      flags_write      <= next_flags_write;
      {flag_x, flag_n, flag_z, flag_v, flag_c} <= next_flags;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  x_follows_c_a: assert property (flags_write |-> flag_x == flag_c) // RL1
    else $error("extend flag differs from carry");
  neg_msb_a: assert property (flags_write |->                       // RL2
    flag_n == ((result_size == sub_exec_pkg::size_byte) ? result_data[7] :
               (result_size == sub_exec_pkg::size_word) ? result_data[15] :
               result_data[31]))
    else $error("negative flag does not match result sign");
  zero_flag_a: assert property (flags_write &&                      // RL3
    result_size == sub_exec_pkg::size_byte |->
    flag_z == (result_data[7:0] == 8'h00))
    else $error("zero flag wrong for byte result");
  ovf_long_a: assert property (claimed && ea_legal &&               // RL4
    form != sub_exec_pkg::form_to_addr_reg &&
    size == sub_exec_pkg::size_long |=>
    flag_v == ($past(op_a[31]) != $past(op_b[31]) &&
               result_data[31] != $past(op_a[31])))
    else $error("overflow flag wrong for long subtract");
  borrow_long_a: assert property (claimed && ea_legal &&            // RL5
    form != sub_exec_pkg::form_to_addr_reg &&
    size == sub_exec_pkg::size_long |=> flag_c == ($past(op_a) < $past(op_b)))
    else $error("carry flag wrong for long subtract");
  reg_index_a: assert property (claimed && ea_legal |=>             // RL6
    result_reg_index == $past(reg_field))
    else $error("register index not taken from register field");
  to_reg_dir_a: assert property (claimed && ea_legal &&             // RL7
    opmode == `OPM_EA_MINUS_REG_L |=>
    result_form == sub_exec_pkg::form_to_data_reg &&
    result_data == $past(ea_operand) - $past(reg_operand))
    else $error("operand minus register not written to register");
  to_ea_dir_a: assert property (claimed && ea_legal &&              // RL8
    opmode == `OPM_REG_MINUS_EA_L |=>
    result_form == sub_exec_pkg::form_to_ea &&
    result_data == $past(reg_operand) - $past(ea_operand))
    else $error("register minus operand not written to operand");
  byte_areg_a: assert property (claimed &&                          // RL10
    opmode == `OPM_EA_MINUS_REG_B && ea_mode == `EA_MODE_ADDR_DIRECT |=>
    illegal_instr && result_form == sub_exec_pkg::form_none)
    else $error("byte address direct source not rejected");
  dest_direct_a: assert property (claimed && ea_is_dest &&          // RL11
    ea_mode <= `EA_MODE_ADDR_DIRECT |=> illegal_instr)
    else $error("register direct destination not rejected");
  addr_flags_a: assert property (claimed &&                         // RL13
    form == sub_exec_pkg::form_to_addr_reg |=>
    !flags_write && $stable({flag_x, flag_n, flag_z, flag_v, flag_c}))
    else $error("address form touched the flags");
  addr_sext_a: assert property (claimed && ea_legal &&              // RL14
    opmode == `OPM_TO_ADDR_W |=>
    result_data == $past(reg_operand) -
      {{16{$past(ea_operand[15])}}, $past(ea_operand[15:0])})
    else $error("word source not sign-extended");
  addr_route_a: assert property (claimed &&                         // RL18
    opmode == `OPM_TO_ADDR_L && ea_mode == `EA_MODE_ADDR_DIRECT |=>
    result_form == sub_exec_pkg::form_to_addr_reg &&
    result_size == sub_exec_pkg::size_long && !illegal_instr)
    else $error("long address form not routed");
  // a word claimed at one edge retires at the next
  done_follows_a: assert property (claimed |=> exec_done)
    else $error("claimed word did not complete");
  other_group_a: assert property (!claimed |=> !exec_done)
    else $error("unclaimed word completed");
  zero_long_a: assert property (flags_write && // RL3
    result_size == sub_exec_pkg::size_long |-> flag_z == !(|result_data))
    else $error("zero flag wrong for long result");
  src_imm_a: assert property (claimed && !ea_is_dest && // RL9
    ea_mode == `EA_MODE_EXTENDED && ea_reg == `EA_REG_IMMEDIATE |=>
    !illegal_instr)
    else $error("immediate source rejected");
  dest_abs_a: assert property (claimed && ea_is_dest && // RL11
    ea_mode == `EA_MODE_EXTENDED && ea_reg <= `EA_REG_ABS_LONG |=>
    !illegal_instr)
    else $error("absolute destination rejected");
  illegal_hold_a: assert property (claimed && !ea_legal |=> // RL11
    illegal_instr && !flags_write && $stable(result_data))
    else $error("illegal form changed the result");
  flags_hold_a: assert property (!flags_write |-> // RL13
    $stable({flag_x, flag_n, flag_z, flag_v, flag_c}))
    else $error("flags moved without a flag write");
  addr_size_a: assert property (claimed && ea_legal && // RL15
    form == sub_exec_pkg::form_to_addr_reg |=>
    result_size == sub_exec_pkg::size_long)
    else $error("address form not reported as long");

  to_reg_c: cover property (exec_done &&
    result_form == sub_exec_pkg::form_to_data_reg && flag_v);
  to_ea_c: cover property (exec_done &&
    result_form == sub_exec_pkg::form_to_ea && flag_c);
  addr_word_c: cover property (claimed && opmode == `OPM_TO_ADDR_W ##1
    exec_done);
  illegal_c: cover property (illegal_instr);
  illegal_dest_c: cover property (claimed && ea_is_dest ##1
    illegal_instr);
endmodule // subtract_and_subtract_address_exec

`default_nettype wire

// ### subtract_and_subtract_address_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none

module subtract_and_subtract_address_exec_tb;
  // ------------------------------------------
  // signals
  // ------------------------------------------
  logic                     core_clk;
  logic                     rst;
  logic                     instr_valid;
  logic [15:0]              instr_word;
  logic [31:0]              mem_value;
  logic [31:0]              reg_operand;
  logic [31:0]              ea_operand;
  logic                     exec_done;
  logic                     illegal_instr;
  logic [31:0]              result_data;
  sub_exec_pkg::exec_form_t result_form;
  logic [2:0]               result_reg_index;
  sub_exec_pkg::op_size_t   result_size;
  logic                     flags_write;
  logic                     flag_x, flag_n, flag_z, flag_v, flag_c;
  logic [4:0]               flg;
  int                       errors;
  int                       check_count;

  assign flg = {flag_x, flag_n, flag_z, flag_v, flag_c};

  subtract_and_subtract_address_exec subtract_and_subtract_address_exec_i (
    .core_clk         (core_clk),
    .rst              (rst),
    .instr_valid      (instr_valid),
    .instr_word       (instr_word),
    .reg_operand      (reg_operand),
    .ea_operand       (ea_operand),
    .exec_done        (exec_done),
    .illegal_instr    (illegal_instr),
    .result_data      (result_data),
    .result_form      (result_form),
    .result_reg_index (result_reg_index),
    .result_size      (result_size),
    .flags_write      (flags_write),
    .flag_x           (flag_x),
    .flag_n           (flag_n),
    .flag_z           (flag_z),
    .flag_v           (flag_v),
    .flag_c           (flag_c)
  );

  sub_operand_model sub_operand_model_i (
    .instr_word  (instr_word),
    .mem_value   (mem_value),
    .reg_operand (reg_operand),
    .ea_operand  (ea_operand)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ------------------------------------------
  // helpers
  // ------------------------------------------
  function automatic logic [31:0] dval(int i);
    return 32'h8000_0001 + i * 32'h0101_0101;
  endfunction

  function automatic logic [31:0] aval(int i);
    return 32'h0000_7FF0 + i * 32'h0010_0000;
  endfunction

  // upper bits come from the minuend, as the pipeline merges them
  task automatic ref_sub(input logic [31:0] a, input logic [31:0] b,
      input logic [1:0] sz, output logic [31:0] d, output logic [4:0] f);
    logic [31:0] m;
    logic [32:0] full;
    int          w;
    w = (sz == 2'h0) ? 8 : (sz == 2'h1) ? 16 : 32;
    m = (w == 32) ? 32'hFFFF_FFFF : ((32'h1 << w) - 32'h1);
    full = {1'b0, a & m} - {1'b0, b & m};
    d = (a & ~m) | (full[31:0] & m);
    f[4] = full[32];
    f[3] = full[w-1];
    f[2] = (full[31:0] & m) == 32'h0;
    f[1] = (a[w-1] != b[w-1]) && (full[w-1] != a[w-1]);
    f[0] = full[32];
  endtask

  task automatic chk_val(input string name, input logic [31:0] exp,
      input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic issue(input logic [15:0] w, input logic [31:0] v);
    @(negedge core_clk);
    instr_valid = 1'b1;
    instr_word = w;
    mem_value = v;
    @(negedge core_clk);
    instr_valid = 1'b0;
  endtask

  task automatic chk_done(input logic [1:0] form, input logic [2:0] idx,
      input logic [1:0] sz, input logic [31:0] d, input logic [4:0] f,
      input logic fw);
    chk_val("exec_done", 32'h1, {31'h0, exec_done});
    chk_val("illegal", 32'h0, {31'h0, illegal_instr});
    chk_val("form", {30'h0, form}, {30'h0, result_form});
    chk_val("index", {29'h0, idx}, {29'h0, result_reg_index});
    chk_val("size", {30'h0, sz}, {30'h0, result_size});
    chk_val("data", d, result_data);
    chk_val("flags_write", {31'h0, fw}, {31'h0, flags_write});
    chk_val("flags", {27'h0, f}, {27'h0, flg});
  endtask

  task automatic run_gen(input logic [2:0] opm, input logic [2:0] r,
      input logic [5:0] ea, input logic [31:0] mem);
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] d;
    logic [4:0]  f;
    a = opm[2] ? dval(r) : mem;
    b = opm[2] ? mem : dval(r);
    ref_sub(a, b, opm[1:0], d, f);
    issue({4'hD, r, opm, ea}, mem);
    chk_done(opm[2] ? 2'h2 : 2'h1, r, opm[1:0], d, f, 1'b1);
  endtask

  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task automatic t_reset();
    chk_val("exec_done", 32'h0, {31'h0, exec_done});
    chk_val("data", 32'h0, result_data);
    chk_val("form", 32'h0, {30'h0, result_form});
    chk_val("flags", 32'h0, {27'h0, flg});
  endtask

  // zero at every size and direction, borrow at all but long register minus operand, signed overflow at byte and long only
  task automatic t_general();
    logic [2:0]  opm;
    logic [2:0]  r;
    logic [31:0] mem;
    for (int i = 0; i < 6; i++) begin
      opm = (i < 3) ? i[2:0] : i[2:0] + 3'h1;
      for (int j = 0; j < 3; j++) begin
        r = 3'(j * 3 + 1);
        for (int k = 0; k < 3; k++) begin
          mem = (k == 0) ? dval(r) : (k == 1) ? 32'h7FFF_FF80 : 32'h1;
          run_gen(opm, r, 6'h12, mem);
        end
      end
    end
  endtask

  task automatic t_legal();
    logic [9:0]  tbl [14] = '{10'h208, 10'h048, 10'h0BC, 10'h23D,
                              10'h0BA, 10'h070, 10'h300, 10'h348,
                              10'h3BC, 10'h33A, 10'h33B, 10'h1B9,
                              10'h160, 10'h138};
    logic [31:0] d;
    logic [4:0]  f;
    for (int i = 0; i < 14; i++) begin
      if (!tbl[i][9]) begin
        run_gen(tbl[i][8:6], 3'h2, tbl[i][5:0], 32'h0000_0055);
      end else begin
        d = result_data;
        f = flg;
        issue({4'hD, 3'h2, tbl[i][8:0]}, 32'h0000_0055);
        chk_val("exec_done", 32'h1, {31'h0, exec_done});
        chk_val("illegal", 32'h1, {31'h0, illegal_instr});
        chk_val("form", 32'h0, {30'h0, result_form});
        chk_val("flags_write", 32'h0, {31'h0, flags_write});
        chk_val("data", d, result_data);
        chk_val("flags", {27'h0, f}, {27'h0, flg});
      end
    end
  endtask

  // negative word source exposes a missing sign extension
  task automatic t_addr();
    logic [5:0]  src [3] = '{6'h0A, 6'h3C, 6'h05};
    logic [31:0] b;
    logic [31:0] mem;
    logic [4:0]  f;
    logic [2:0]  opm;
    for (int i = 0; i < 2; i++)
      for (int r = 0; r < 8; r += 7)
        for (int s = 0; s < 3; s++) begin
          opm = (i == 0) ? 3'h3 : 3'h7;
          mem = 32'h1234_8001 + 32'(s);
          b = (i == 0) ? {{16{mem[15]}}, mem[15:0]} : mem;
          f = flg;
          issue({4'hD, 3'(r), opm, src[s]}, mem);
          chk_done(2'h3, 3'(r), 2'h2, aval(r) - b, f, 1'b0);
        end
  endtask

  task automatic t_other();
    issue(16'h9081, 32'h1);
    chk_val("exec_done", 32'h0, {31'h0, exec_done});
    @(negedge core_clk);
    instr_valid = 1'b1;
    instr_word = 16'hD040;
    mem_value = 32'h3;
    @(negedge core_clk);
    instr_word = 16'hD0C8;
    chk_val("form", 32'h1, {30'h0, result_form});
    @(negedge core_clk);
    instr_valid = 1'b0;
    chk_val("exec_done", 32'h1, {31'h0, exec_done});
    chk_val("form", 32'h3, {30'h0, result_form});
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------
  initial begin
    errors = 0;
    check_count = 0;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0;
    mem_value = 32'h0;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_general();
    t_legal();
    t_addr();
    t_other();
    wrap_up();
  end

  // about 80 operations of two cycles each; generous margin
  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    wrap_up();
  end
endmodule // subtract_and_subtract_address_exec_tb

`default_nettype wire
